// ---- csa_top.v ----
// Purpose: Capacitive-sense accumulate, scale, threshold compare and auto-scan stepping
// Assumes: Converter delivers one 16-bit sample with a one-cycle valid pulse
// Notes: Registers on APB; events leave as one-cycle pulses
//     0x00 config: bits 2:0 samples per result, bit 3 auto-scan enable and restart
//     0x04 channel select; a write restarts the running sum
//     0x08 scan start channel, 0x0C scan end channel
//     0x10 threshold, 0x14 result (read only)
//     0x18 status: bit 0 done, bit 1 greater, bit 2 scanning; bits 1:0 write one to clear
//     0x1C priority: bit 0 done event, bit 1 greater event
//     Unmapped offsets answer with pslverr and read as zero
//     A sample that meets a config or channel write is dropped with the running sum
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "csa_map.vh"
module csa_top (
    input wire core_clk,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sample_valid,
    input wire [15:0] sample_data,
    output reg [4:0] channel_select,
    output reg conversion_done_irq,
    output reg greater_irq,
    output reg done_irq_priority,
    output reg greater_irq_priority
);
    reg [2:0] accum_count_select_reg;
    reg scan_en_reg;
    reg [4:0] scan_start_channel_reg;
    reg [4:0] scan_end_channel_reg;
    reg [15:0] threshold_reg;
    reg [15:0] result_reg;
    reg scanning_reg;
    reg [1:0] seen_flags_reg;
    wire [1:0] seen_set;
    reg [21:0] accum_reg;
    reg [6:0] count_reg;
    reg [6:0] target;
    reg [2:0] shift;
    reg [21:0] sum_next;
    reg [15:0] scaled;
    reg last_sample;
    reg is_greater;
    reg [4:0] chan_next;
    wire wr_en;
    wire rd_en;
    wire cfg_wr;
    wire chan_wr;
    reg [31:0] rd_mux;
    reg addr_ok;
    wire start_wr;
    wire end_wr;
    wire thresh_wr;
    wire prio_wr;
    wire status_wr;
    wire sample_take;
    genvar flag_idx;

    // ==============================================================
    // APB decode: zero wait states, pready in access phase
    assign wr_en = psel & penable & pwrite & pready;
    assign rd_en = psel & penable & ~pwrite;
    assign cfg_wr = wr_en & (paddr == `CSA_CONFIG_OFF);
    assign chan_wr = wr_en & (paddr == `CSA_CHAN_OFF);
    assign start_wr = wr_en & (paddr == `CSA_SCAN_START_OFF);
    assign end_wr = wr_en & (paddr == `CSA_SCAN_END_OFF);
    assign thresh_wr = wr_en & (paddr == `CSA_THRESH_OFF);
    assign prio_wr = wr_en & (paddr == `CSA_PRIO_OFF);
    assign status_wr = wr_en & (paddr == `CSA_STATUS_OFF);

    // Samples meeting a restart are dropped, so no event can follow a lost run
    assign sample_take = sample_valid & ~(cfg_wr | chan_wr);

    // Read mux and address check
    always @* begin
        rd_mux = 32'h00000000;
        addr_ok = 1'b1;
        case (paddr)
            `CSA_CONFIG_OFF: rd_mux = {28'h0000000, scan_en_reg, accum_count_select_reg};
            `CSA_CHAN_OFF: rd_mux = {27'h0000000, channel_select};
            `CSA_SCAN_START_OFF: rd_mux = {27'h0000000, scan_start_channel_reg};
            `CSA_SCAN_END_OFF: rd_mux = {27'h0000000, scan_end_channel_reg};
            `CSA_THRESH_OFF: rd_mux = {16'h0000, threshold_reg};
            `CSA_RESULT_OFF: rd_mux = {16'h0000, result_reg};
            `CSA_STATUS_OFF: rd_mux = {29'h00000000, scanning_reg, seen_flags_reg};
            `CSA_PRIO_OFF: rd_mux = {30'h00000000, greater_irq_priority,
                done_irq_priority};
            default: addr_ok = 1'b0;
        endcase
    end

    // ==============================================================
    // Accumulation count decode
    always @* begin
        case (accum_count_select_reg)
            3'h0: begin
                target = 7'h01;
                shift = 3'h0;
            end
            3'h1: begin
                target = 7'h04;
                shift = 3'h2;
            end
            3'h2: begin
                target = 7'h08;
                shift = 3'h3;
            end
            3'h3: begin
                target = 7'h10;
                shift = 3'h4;
            end
            3'h4: begin
                target = 7'h20;
                shift = 3'h5;
            end
            default: begin
                target = 7'h40;
                shift = 3'h6;
            end
        endcase
    end

    // Sum, scale, compare and next channel
    always @* begin
        sum_next = accum_reg + {6'h00, sample_data};
        scaled = sum_next[15:0];
        case (shift)
            3'h0: scaled = sum_next[15:0];
            3'h2: scaled = sum_next[17:2];
            3'h3: scaled = sum_next[18:3];
            3'h4: scaled = sum_next[19:4];
            3'h5: scaled = sum_next[20:5];
            default: scaled = sum_next[21:6];
        endcase
        last_sample = sample_take & ((count_reg + 7'h01) >= target);
        is_greater = scaled > threshold_reg;
        if (channel_select >= scan_end_channel_reg) begin
            chan_next = scan_start_channel_reg;
        end else begin
            chan_next = channel_select + 5'h01;
        end
    end

    // ==============================================================
    // APB answer: pready in the first access cycle, read data taken in setup
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (rd_en & pready) begin
                prdata <= 32'h00000000; // Read data stands for the access cycle only
            end else if (psel & ~penable & ~pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // Configuration: samples per result and auto-scan enable
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            accum_count_select_reg <= `CSA_ACU_RST;
            scan_en_reg <= `CSA_SCAN_RST;
        end else if (cfg_wr) begin
            accum_count_select_reg <= pwdata[`CSA_CFG_ACU_MSB:`CSA_CFG_ACU_LSB];
            scan_en_reg <= pwdata[`CSA_CFG_SCAN_BIT];
        end
    end

    // Scan window limits
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            scan_start_channel_reg <= `CSA_CHAN_RST;
            scan_end_channel_reg <= `CSA_CHAN_RST;
        end else begin
            if (start_wr) begin
                scan_start_channel_reg <= pwdata[4:0];
            end
            if (end_wr) begin
                scan_end_channel_reg <= pwdata[4:0];
            end
        end
    end

    // Threshold for the greater comparison
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            threshold_reg <= `CSA_THRESH_RST;
        end else if (thresh_wr) begin
            threshold_reg <= pwdata[15:0];
        end
    end

    // Event priority bits, both low after reset
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            done_irq_priority <= `CSA_PRIO_BIT_RST;
            greater_irq_priority <= `CSA_PRIO_BIT_RST;
        end else if (prio_wr) begin
            done_irq_priority <= pwdata[`CSA_PRIO_DONE_BIT];
            greater_irq_priority <= pwdata[`CSA_PRIO_GREATER_BIT];
        end
    end

    // ==============================================================
    // Event pulses, raised on the edge that takes the last sample, together with the result
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            conversion_done_irq <= 1'b0;
            greater_irq <= 1'b0;
        end else begin
            conversion_done_irq <= last_sample;
            greater_irq <= last_sample & is_greater;
        end
    end

    // Status flags, one per event: write one clears, a new event wins over the clear
    assign seen_set = {last_sample & is_greater, last_sample};
    generate
        for (flag_idx = 0; flag_idx < 2; flag_idx = flag_idx + 1) begin : g_seen_flag
            always @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    seen_flags_reg[flag_idx] <= 1'b0;
                end else if (seen_set[flag_idx]) begin
                    seen_flags_reg[flag_idx] <= 1'b1;
                end else if (status_wr & pwdata[flag_idx]) begin
                    seen_flags_reg[flag_idx] <= 1'b0;
                end
            end
        end
    endgenerate

    // Scan run state: started by a config write, stopped by a greater result
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            scanning_reg <= 1'b0;
        end else if (cfg_wr) begin
            scanning_reg <= pwdata[`CSA_CFG_SCAN_BIT];
        end else if (last_sample & scan_en_reg & scanning_reg & is_greater) begin
            scanning_reg <= 1'b0;
        end
    end

    // ==============================================================
    // Running sum and sample count, restarted per run and on any restart write
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            accum_reg <= 22'h000000;
            count_reg <= 7'h00;
        end else if (cfg_wr | chan_wr | last_sample) begin
            accum_reg <= 22'h000000;
            count_reg <= 7'h00;
        end else if (sample_take) begin
            accum_reg <= sum_next;
            count_reg <= count_reg + 7'h01;
        end
    end

    // Result register: scaled sum of the finished run
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_reg <= `CSA_RESULT_RST;
        end else if (last_sample) begin
            result_reg <= scaled;
        end
    end

    // Channel selection: software write, or one step per result not greater than the threshold while scanning
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            channel_select <= `CSA_CHAN_RST;
        end else if (chan_wr) begin
            channel_select <= pwdata[4:0];
        end else if (last_sample & scan_en_reg & scanning_reg & ~is_greater) begin
            channel_select <= chan_next;
        end
    end
endmodule // csa_top

// ---- csa_map.vh ----
// Purpose: Register offsets, field positions and reset values for the cap-sense accumulator
// Assumes: APB, 32-bit data, one aligned word per register
// Notes: Included by the design, the checker and the bench
`ifndef CSA_MAP_VH
`define CSA_MAP_VH
// ==============================================================
// Register byte offsets
`define CSA_CONFIG_OFF 12'h000
`define CSA_CHAN_OFF 12'h004
`define CSA_SCAN_START_OFF 12'h008
`define CSA_SCAN_END_OFF 12'h00C
`define CSA_THRESH_OFF 12'h010
`define CSA_RESULT_OFF 12'h014
`define CSA_STATUS_OFF 12'h018
`define CSA_PRIO_OFF 12'h01C
// ==============================================================
// Config field positions
`define CSA_CFG_ACU_LSB 0
`define CSA_CFG_ACU_MSB 2
`define CSA_CFG_SCAN_BIT 3
// Priority field positions
`define CSA_PRIO_DONE_BIT 0
`define CSA_PRIO_GREATER_BIT 1
// ==============================================================
// Reset values
`define CSA_ACU_RST 3'h0
`define CSA_SCAN_RST 1'b0
`define CSA_CHAN_RST 5'h00
`define CSA_THRESH_RST 16'h0000
`define CSA_RESULT_RST 16'h0000
`define CSA_PRIO_BIT_RST 1'b0
`define CSA_CHAN_W 5
`endif

// ---- csa_assertions.sv ----
// Purpose: Port checks for csa_top
// Assumes: One clock, reset async low
// Notes: Bound to csa_top from the bench
`timescale 1ns/10ps
`include "csa_map.vh"
module csa_assertions (
    input wire core_clk,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire sample_valid,
    input wire [4:0] channel_select,
    input wire conversion_done_irq,
    input wire greater_irq,
    input wire done_irq_priority,
    input wire greater_irq_priority
);
    // ==============================================================
    // Accepted write, seen one cycle later through $past
    wire wr = psel && penable && pready && pwrite;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("setup without ready");
    property p_err; pslverr |-> pready && prdata == 32'h00000000; endproperty
    a_err: assert property (p_err) else $error("bad error answer");
    property p_done; conversion_done_irq |-> $past(sample_valid); endproperty
    a_done: assert property (p_done) else $error("done without sample");
    property p_gt; greater_irq |-> conversion_done_irq; endproperty
    a_gt: assert property (p_gt) else $error("greater without result");
    property p_hold; greater_irq |-> $stable(channel_select); endproperty
    a_hold: assert property (p_hold) else $error("channel moved on greater");
    property p_chg; $changed(channel_select) |-> conversion_done_irq || $past(wr); endproperty
    a_chg: assert property (p_chg) else $error("channel moved alone");
    property p_prio;
        $changed({greater_irq_priority, done_irq_priority}) |->
            $past(wr) && $past(paddr) == `CSA_PRIO_OFF;
    endproperty
    a_prio: assert property (p_prio) else $error("priority moved alone");
    property p_rdp;
        psel && penable && pready && !pwrite && paddr == `CSA_PRIO_OFF |->
            prdata == {30'h00000000, greater_irq_priority, done_irq_priority};
    endproperty
    a_rdp: assert property (p_rdp) else $error("priority readback");
    c_gt: cover property (greater_irq);
    c_dn: cover property (conversion_done_irq && !greater_irq);
    c_er: cover property (pslverr);
endmodule // csa_assertions

// ---- csa_conv_model.sv ----
// Purpose: Converter model feeding samples
// Assumes: One sample per valid pulse
// Notes: Data line shows inverse of last value in gaps and after a send with no gaps
`timescale 1ns/10ps
module csa_conv_model (
    input wire core_clk,
    output reg sample_valid,
    output reg [15:0] sample_data
);
    // ==============================================================
    // Idle at time zero
    initial begin
        sample_valid = 1'b0;
        sample_data = 16'h0000;
    end
    // Sends n samples base, base+1, ... with gap idle cycles after each
    task send(input int n, input logic [15:0] base, input int gap);
        int i;
        int g;
        for (i = 0; i < n; i++) begin
            @(posedge core_clk);
            sample_valid <= 1'b1;
            sample_data <= base + i[15:0];
            for (g = 0; g < gap; g++) begin
                @(posedge core_clk);
                sample_valid <= 1'b0;
                sample_data <= ~(base + i[15:0]);
            end
        end
        @(posedge core_clk);
        sample_valid <= 1'b0;
        sample_data <= ~sample_data;
    endtask
endmodule // csa_conv_model

// ---- tb_cap_sense_accumulate_scan.sv ----
// Purpose: Self-checking bench for csa_top
// Assumes: APB answer within the bench's wait bound
// Notes: Random samples and thresholds from a fixed seed
`timescale 1ns/10ps
`include "csa_map.vh"
module tb_cap_sense_accumulate_scan;
    reg core_clk = 1'b0;
    reg arst_n = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h00000000;
    wire [31:0] prdata;
    wire pready, pslverr, sample_valid, conversion_done_irq, greater_irq;
    wire done_irq_priority, greater_irq_priority;
    wire [15:0] sample_data;
    wire [4:0] channel_select;
    int errors = 0;
    int comparisons = 0;
    int ndone = 0;
    int m, v, thr, i, ch, n0;
    logic [31:0] rd;
    logic err, gt;
    // ==============================================================
    // Clock, design, converter and result counter
    always #5 core_clk = ~core_clk;
    csa_top u_csa_top (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sample_valid, .sample_data, .channel_select, .conversion_done_irq,
        .greater_irq, .done_irq_priority, .greater_irq_priority);
    csa_conv_model u_csa_conv_model (.core_clk, .sample_valid, .sample_data);
    // Count one-cycle done pulses and keep the greater flag that came with each
    always @(posedge core_clk) begin
        if (conversion_done_irq === 1'b1) begin
            ndone <= ndone + 1;
            gt <= greater_irq;
        end
    end
    // ==============================================================
    // Tasks and expectations
    task stop_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin errors++; stop_test; end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_done;
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge core_clk);
            if (ndone != n0) break;
        end
        if (n == 400) begin errors++; stop_test; end
    endtask
    function automatic int cnt(int s);
        return (s == 0) ? 1 : (s > 5) ? 64 : (2 << s);
    endfunction
    function automatic int exp_res(int b, int k);
        return (k * b + k * (k - 1) / 2) / k;
    endfunction
    // ==============================================================
    // Main sequence
    initial begin
        void'($urandom(32'h0000AC57));
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        apb(0, `CSA_PRIO_OFF, 0); chk("prio_rst", 32'h00000000, rd);
        chk("prio_pins_rst", 32'h00000000, {greater_irq_priority, done_irq_priority});
        apb(0, 12'h020, 0); chk("unmapped_err", 32'h00000001, {31'h00000000, err});
        apb(1, `CSA_PRIO_OFF, 3); apb(0, `CSA_PRIO_OFF, 0); chk("prio", 32'h00000003, rd);
        chk("prio_pins", 32'h00000003, {greater_irq_priority, done_irq_priority});
        for (i = 0; i < 8; i++) begin
            m = cnt(i);
            v = $urandom_range(16'hFF00);
            thr = (i == 3) ? exp_res(v, m) : (i == 4) ? exp_res(v, m) - 1 : $urandom_range(16'hFFFF);
            apb(1, `CSA_CONFIG_OFF, i);
            apb(1, `CSA_THRESH_OFF, thr);
            u_csa_conv_model.send(2, ~v[15:0], 0);
            ch = $urandom_range(31);
            apb(1, `CSA_CHAN_OFF, ch);
            n0 = ndone;
            u_csa_conv_model.send(m, v[15:0], i % 3);
            wait_done;
            chk("greater", exp_res(v, m) > thr, gt);
            apb(0, `CSA_RESULT_OFF, 0); chk("result", exp_res(v, m), rd);
            chk("done_count", 1, ndone - n0);
            chk("chan_kept", ch, channel_select);
        end
        apb(1, `CSA_SCAN_START_OFF, 2); apb(1, `CSA_SCAN_END_OFF, 4);
        apb(1, `CSA_THRESH_OFF, 32'h0000FFFF); apb(1, `CSA_CONFIG_OFF, 32'h00000008);
        for (i = 0; i < 5; i++) begin
            ch = channel_select;
            n0 = ndone;
            u_csa_conv_model.send(1, i[15:0], 0);
            wait_done;
            chk("scan_step", (ch >= 4) ? 2 : ch + 1, channel_select);
        end
        apb(1, `CSA_THRESH_OFF, 0);
        ch = channel_select;
        for (i = 0; i < 2; i++) begin
            n0 = ndone;
            u_csa_conv_model.send(1, 16'h0100, 0);
            wait_done;
            chk("scan_gt", 1, gt);
            chk("scan_hold", ch, channel_select);
        end
        // Scan stopped, both events seen; then write one clears both flags
        apb(0, `CSA_STATUS_OFF, 0); chk("status", 32'h00000003, rd);
        apb(1, `CSA_STATUS_OFF, 3);
        apb(0, `CSA_STATUS_OFF, 0); chk("status_clr", 32'h00000000, rd);
        stop_test;
    end
endmodule // tb_cap_sense_accumulate_scan
bind csa_top csa_assertions u_csa_assertions (.core_clk, .arst_n, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .sample_valid, .channel_select, .conversion_done_irq,
    .greater_irq, .done_irq_priority, .greater_irq_priority);
